// ===== pkg/dadec_pkg.sv
// constants, field layouts and carrier types for the data area map decoder
// assumes one 200 MHz clock shared by the cpu data bus, code fetch and ahb
//
// Summary of operation
// [R01] data 0x0000-003F, 0x0F00-0FFF, 0x0E40-0EFF go to peripheral windows
// [R02] data 0x0040-0x083F go to the on-chip ram
// [R03] ram is never cleared by hardware; software must initialise it
// [R04] after reset the boot rom is mapped in neither code nor data area
// [R05] boot select set plus key commit maps boot rom at 0x1000-0x17FF
// [R06] data reads of 0x1000-0x17FF return 0xFF while boot rom unmapped
// [R07] outside serial programming mode only the lowest 2 KB are visible
// [R08] holding register writes only store; key 0xD5 copies them active
// [R09] the active setting is readable through a separate readback register
// [R10] data 0x8000-0xFFFF go to the flash array
// [R11] software must not touch reserved addresses in peripheral windows
// [R12] code fetches at 0x8000-0xFFFF go to the flash array
// [R13] reset loads holding and active registers with their defaults
package dadec_pkg;
  localparam logic [15:0] PW_LOW_LO = 16'h0000;
  localparam logic [15:0] PW_LOW_HI = 16'h003F;
  localparam logic [15:0] PW_HIGH_LO = 16'h0F00;
  localparam logic [15:0] PW_HIGH_HI = 16'h0FFF;
  localparam logic [15:0] PW_EXT_LO = 16'h0E40;
  localparam logic [15:0] PW_EXT_HI = 16'h0EFF;
  localparam logic [15:0] RAM_LO = 16'h0040;
  localparam logic [15:0] RAM_HI = 16'h083F;
  localparam logic [15:0] BOOT_LO = 16'h1000;
  localparam logic [15:0] BOOT_HI = 16'h17FF;
  localparam logic [15:0] BOOT_SERIAL_HI = 16'h1FFF;
  localparam logic [15:0] FLASH_LO = 16'h8000;
  localparam logic [15:0] FLASH_HI = 16'hFFFF;
  localparam int RAM_DEPTH = 2048;
  localparam int RAM_AW = 11;
  localparam int BOOT_AW = 12;
  localparam int BOOT_NORMAL_TOP = 11;
  // register indices; byte address on ahb is four times the index
  localparam logic [11:0] IDX_HOLD = 12'hFD0;
  localparam logic [11:0] IDX_KEY = 12'hFD1;
  localparam logic [11:0] IDX_READBACK = 12'hFD2;
  localparam logic [7:0] COMMIT_KEY = 8'hD5;
  localparam logic [7:0] HOLD_RESET = 8'h40;
  localparam int BOOT_SEL_BIT = 4;
  localparam logic [7:0] BOOT_FILL = 8'hFF;
  localparam logic [7:0] UNMAPPED_FILL = 8'h00;
  localparam logic [31:0] AHB_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic periph_low;
    logic periph_high;
    logic periph_ext;
    logic ram;
    logic boot;
    logic flash;
    logic boot_fill;
  } dadec_sel_t;

  typedef enum logic [1:0] {
    AH_IDLE,
    AH_WR,
    AH_RD_WAIT,
    AH_RD_DONE
  } dadec_ahb_st_t;
endpackage : dadec_pkg

// ===== rtl/dadec_region_decode.sv
// one address decoder for either the code area or the data area
// assumes a stable 16-bit address; purely combinational
`timescale 1ns/1ps
module dadec_region_decode (
  input wire logic [15:0] i_addr,
  input wire logic i_is_code,
  input wire logic i_boot_mapped,
  input wire logic i_serial_mode,
  output dadec_pkg::dadec_sel_t o_sel,
  output logic [dadec_pkg::BOOT_AW-1:0] o_boot_addr
);
  logic [15:0] boot_top;
  logic in_boot;
  logic [15:0] boot_off;

  always_comb begin
    // serial programming mode opens the whole boot rom
    boot_top = i_serial_mode ? dadec_pkg::BOOT_SERIAL_HI : dadec_pkg::BOOT_HI;
    in_boot = (i_addr >= dadec_pkg::BOOT_LO) && (i_addr <= boot_top);
    boot_off = i_addr - dadec_pkg::BOOT_LO;
    o_sel = '0;
    o_boot_addr = boot_off[dadec_pkg::BOOT_AW-1:0];
    if (!i_serial_mode) begin
      o_boot_addr[dadec_pkg::BOOT_NORMAL_TOP] = 1'b0; // R07
    end
    if (!i_is_code) begin
      o_sel.periph_low = (i_addr <= dadec_pkg::PW_LOW_HI); // R01
      o_sel.periph_high = (i_addr >= dadec_pkg::PW_HIGH_LO) &&
                          (i_addr <= dadec_pkg::PW_HIGH_HI); // R01
      o_sel.periph_ext = (i_addr >= dadec_pkg::PW_EXT_LO) &&
                         (i_addr <= dadec_pkg::PW_EXT_HI); // R01
      o_sel.ram = (i_addr >= dadec_pkg::RAM_LO) &&
                  (i_addr <= dadec_pkg::RAM_HI); // R02
      o_sel.boot_fill = in_boot && !i_boot_mapped; // R06
    end
    o_sel.boot = in_boot && i_boot_mapped; // R05
    o_sel.flash = (i_addr >= dadec_pkg::FLASH_LO); // R10 R12
  end
endmodule : dadec_region_decode

// ===== rtl/dadec_top.sv
// data area map decoder: cpu data and code fetch steering, on-chip ram,
// double-buffered boot map control reached over an ahb-lite slave
// assumes targets answer reads one cycle after their select
`timescale 1ns/1ps
module dadec_top (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_serial_mode_pin,
  input wire logic i_data_req,
  input wire logic i_data_we,
  input wire logic [15:0] i_data_addr,
  input wire logic [7:0] i_data_wdata,
  output dadec_pkg::dadec_sel_t o_data_sel,
  output logic [dadec_pkg::BOOT_AW-1:0] o_data_boot_addr,
  output logic [7:0] o_data_rdata,
  output logic o_data_rvalid,
  input wire logic [7:0] i_periph_rdata,
  input wire logic [7:0] i_boot_rdata,
  input wire logic [7:0] i_flash_rdata,
  input wire logic i_code_req,
  input wire logic [15:0] i_code_addr,
  output dadec_pkg::dadec_sel_t o_code_sel,
  output logic [dadec_pkg::BOOT_AW-1:0] o_code_boot_addr,
  output logic o_boot_mapped
);
  logic serial_meta_q;
  logic serial_q;
  logic [7:0] hold_q;
  logic [7:0] active_q;
  dadec_pkg::dadec_ahb_st_t ah_st_q;
  logic [11:0] ah_idx_q;
  logic ah_ok_q;
  logic [31:0] hrdata_q;
  logic commit;
  logic boot_mapped;
  dadec_pkg::dadec_sel_t dsel_raw;
  dadec_pkg::dadec_sel_t csel_raw;
  dadec_pkg::dadec_sel_t rsrc_q;
  logic rpend_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic [7:0] ram_mem [dadec_pkg::RAM_DEPTH];
  logic [7:0] ram_rd_q;
  logic [15:0] ram_off;

  // serial programming strap comes from a pin
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      serial_meta_q <= 1'b0;
      serial_q <= 1'b0;
    end else begin
      serial_meta_q <= i_serial_mode_pin;
      serial_q <= serial_meta_q;
    end
  end

  assign boot_mapped = active_q[dadec_pkg::BOOT_SEL_BIT];
  assign o_boot_mapped = boot_mapped;

  dadec_region_decode u_data_dec (
    .i_addr(i_data_addr),
    .i_is_code(1'b0),
    .i_boot_mapped(boot_mapped),
    .i_serial_mode(serial_q),
    .o_sel(dsel_raw),
    .o_boot_addr(o_data_boot_addr)
  );

  dadec_region_decode u_code_dec (
    .i_addr(i_code_addr),
    .i_is_code(1'b1),
    .i_boot_mapped(boot_mapped),
    .i_serial_mode(serial_q),
    .o_sel(csel_raw),
    .o_boot_addr(o_code_boot_addr)
  );

  assign o_data_sel = i_data_req ? dsel_raw : '0;
  assign o_code_sel = i_code_req ? csel_raw : '0;

  // ahb-lite slave: writes take no wait state, reads take one
  function automatic logic reg_hit(input logic [31:0] a);
    reg_hit = (a[31:14] == '0) && (a[1:0] == 2'b00);
  endfunction : reg_hit

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ah_st_q <= dadec_pkg::AH_IDLE;
      ah_idx_q <= '0;
      ah_ok_q <= 1'b0;
    end else begin
      case (ah_st_q)
        dadec_pkg::AH_RD_WAIT: begin
          ah_st_q <= dadec_pkg::AH_RD_DONE;
        end
        default: begin
          if (i_hready && i_hsel && i_htrans[1]) begin
            ah_st_q <= i_hwrite ? dadec_pkg::AH_WR : dadec_pkg::AH_RD_WAIT;
            ah_idx_q <= i_haddr[13:2];
            ah_ok_q <= reg_hit(i_haddr);
          end else begin
            ah_st_q <= dadec_pkg::AH_IDLE;
          end
        end
      endcase
    end
  end

  assign o_hreadyout = (ah_st_q != dadec_pkg::AH_RD_WAIT);
  assign o_hresp = 1'b0;
  assign o_hrdata = hrdata_q;

  assign commit = (ah_st_q == dadec_pkg::AH_WR) && ah_ok_q &&
                  (ah_idx_q == dadec_pkg::IDX_KEY) &&
                  (i_hwdata[7:0] == dadec_pkg::COMMIT_KEY); // R08

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      hold_q <= dadec_pkg::HOLD_RESET; // R13
      active_q <= dadec_pkg::HOLD_RESET; // R04 R13
    end else begin
      if ((ah_st_q == dadec_pkg::AH_WR) && ah_ok_q &&
          (ah_idx_q == dadec_pkg::IDX_HOLD)) begin
        hold_q <= i_hwdata[7:0]; // R08
      end
      if (commit) begin
        active_q <= hold_q; // R08 R05
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      hrdata_q <= dadec_pkg::AHB_ZERO;
    end else if (ah_st_q == dadec_pkg::AH_RD_WAIT) begin
      if (ah_ok_q && (ah_idx_q == dadec_pkg::IDX_HOLD)) begin
        hrdata_q <= {24'h00_0000, hold_q};
      end else if (ah_ok_q && (ah_idx_q == dadec_pkg::IDX_READBACK)) begin
        hrdata_q <= {24'h00_0000, active_q}; // R09
      end else begin
        hrdata_q <= dadec_pkg::AHB_ZERO;
      end
    end
  end

  // ram has no reset and is never cleared; contents start undefined
  assign ram_off = i_data_addr - dadec_pkg::RAM_LO;

  always_ff @(posedge i_mclk) begin
    if (i_data_req && dsel_raw.ram) begin
      if (i_data_we) begin
        ram_mem[ram_off[dadec_pkg::RAM_AW-1:0]] <= i_data_wdata; // R02 R03
      end
      ram_rd_q <= ram_mem[ram_off[dadec_pkg::RAM_AW-1:0]];
    end
  end

  // read return: select captured at request, data two edges later
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rpend_q <= 1'b0;
      rsrc_q <= '0;
    end else begin
      rpend_q <= i_data_req && !i_data_we;
      rsrc_q <= dsel_raw;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      rvalid_q <= rpend_q;
      if (rpend_q) begin
        if (rsrc_q.boot_fill) begin
          rdata_q <= dadec_pkg::BOOT_FILL; // R06
        end else if (rsrc_q.ram) begin
          rdata_q <= ram_rd_q;
        end else if (rsrc_q.boot) begin
          rdata_q <= i_boot_rdata;
        end else if (rsrc_q.flash) begin
          rdata_q <= i_flash_rdata;
        end else if (rsrc_q.periph_low || rsrc_q.periph_high ||
                     rsrc_q.periph_ext) begin
          rdata_q <= i_periph_rdata;
        end else begin
          rdata_q <= dadec_pkg::UNMAPPED_FILL;
        end
      end
    end
  end

  assign o_data_rdata = rdata_q;
  assign o_data_rvalid = rvalid_q;

  // checks
  logic hold_wr;
  assign hold_wr = (ah_st_q == dadec_pkg::AH_WR) && ah_ok_q &&
                   (ah_idx_q == dadec_pkg::IDX_HOLD);

  property p_periph_map;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_data_req && (i_data_addr >= 16'h0E40) && (i_data_addr <= 16'h0EFF))
      |-> (o_data_sel.periph_ext && !o_data_sel.periph_high &&
           !o_data_sel.periph_low && !o_data_sel.ram);
  endproperty
  a_periph_map: assert property (p_periph_map) // R01
    else $error("ext window address not steered to ext window");

  property p_ram_map;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_data_req && o_data_sel.ram)
      |-> ((i_data_addr >= 16'h0040) && (i_data_addr <= 16'h083F));
  endproperty
  a_ram_map: assert property (p_ram_map) // R02
    else $error("ram selected outside its range");

  property p_reset_default;
    @(posedge i_mclk) disable iff (!i_rst_n)
      $past(!i_rst_n) |-> (!o_boot_mapped && hold_q == 8'h40 &&
                           active_q == 8'h40);
  endproperty
  a_reset_default: assert property (p_reset_default) // R04
    else $error("control not at default after reset");

  property p_commit_maps;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (commit && hold_q[4]) |=> (o_boot_mapped ##0
        (!(i_code_req && i_code_addr == 16'h1000) || o_code_sel.boot));
  endproperty
  a_commit_maps: assert property (p_commit_maps) // R05
    else $error("boot rom not mapped after key commit");

  property p_fill_ff;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_data_req && !i_data_we && !o_boot_mapped &&
       (i_data_addr >= 16'h1000) && (i_data_addr <= 16'h17FF))
      |-> ##2 (o_data_rvalid && o_data_rdata == 8'hFF);
  endproperty
  a_fill_ff: assert property (p_fill_ff) // R06
    else $error("unmapped boot area did not read 0xFF");

  property p_boot_2k;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (!serial_q && o_data_sel.boot) |-> (o_data_boot_addr[11] == 1'b0 &&
        i_data_addr <= 16'h17FF);
  endproperty
  a_boot_2k: assert property (p_boot_2k) // R07
    else $error("boot rom beyond 2 KB visible outside serial mode");

  // any edge without a key commit, holding writes included, keeps it
  property p_hold_only;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (!commit) |=> $stable(active_q);
  endproperty
  a_hold_only: assert property (p_hold_only) // R08
    else $error("active setting changed without a key commit");

  property p_readback;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (ah_st_q == dadec_pkg::AH_RD_WAIT && ah_ok_q &&
       ah_idx_q == 12'hFD2) |=> (o_hreadyout && o_hrdata == {24'h0,
       $past(active_q)});
  endproperty
  a_readback: assert property (p_readback) // R09
    else $error("readback did not show active setting");

  property p_flash_map;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_data_req && i_data_addr[15]) |-> o_data_sel.flash;
  endproperty
  a_flash_map: assert property (p_flash_map) // R10
    else $error("data flash address not steered to flash");

  property p_code_flash;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_code_req) |-> (o_code_sel.flash == i_code_addr[15] &&
                        !o_code_sel.ram);
  endproperty
  a_code_flash: assert property (p_code_flash) // R12
    else $error("code fetch flash steering wrong");

  c_commit: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    commit && hold_q[4]);
  c_boot_read: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_data_req && !i_data_we && o_data_sel.boot);
  c_hold_then_key: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    hold_wr ##[1:8] commit);
  c_ram_rw: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_data_req && i_data_we && o_data_sel.ram ##1 i_data_req &&
    !i_data_we && o_data_sel.ram);
endmodule : dadec_top

// ===== bench/dadec_targets.sv
// target model: peripheral windows, boot rom and flash array
// assumes the decoder's selects; each target answers the cycle after
`timescale 1ns/1ps
module dadec_targets (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire dadec_pkg::dadec_sel_t i_sel,
  input wire logic [15:0] i_addr,
  input wire logic [dadec_pkg::BOOT_AW-1:0] i_boot_addr,
  output logic [7:0] o_periph_rdata,
  output logic [7:0] o_boot_rdata,
  output logic [7:0] o_flash_rdata
);
  // an unselected target does not hold its last byte, so stale data shows
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_periph_rdata <= 8'h00;
      o_boot_rdata <= 8'h00;
      o_flash_rdata <= 8'h00;
    end else begin
      o_periph_rdata <= (i_sel.periph_low | i_sel.periph_high |
        i_sel.periph_ext) ? i_addr[7:0] ^ 8'h3C : ~o_periph_rdata;
      // upper offset bits folded in so the 2 KB limit shows in the data
      o_boot_rdata <= i_sel.boot ? (i_boot_addr[7:0] ^ 8'hC3 ^
        {i_boot_addr[11:8], 4'h0}) : ~o_boot_rdata;
      o_flash_rdata <= i_sel.flash ? i_addr[7:0] ^ 8'h96 : ~o_flash_rdata;
    end
  end
endmodule : dadec_targets

// ===== bench/data_area_map_decoder_tb_top.sv
// testbench for the data area map decoder
// assumes ahb-lite single word transfers and the target model beside it
`timescale 1ns/1ps
module data_area_map_decoder_tb_top;
  logic i_mclk, i_rst_n, i_hsel, i_hwrite, i_hready, o_hreadyout, o_hresp;
  logic [31:0] i_haddr, i_hwdata, o_hrdata, rd;
  logic [1:0] i_htrans;
  logic [2:0] i_hsize;
  logic i_serial_mode_pin, i_data_req, i_data_we, i_code_req;
  logic [15:0] i_data_addr, i_code_addr;
  logic [7:0] i_data_wdata, o_data_rdata, i_periph_rdata;
  logic [7:0] i_boot_rdata, i_flash_rdata;
  logic o_data_rvalid, o_boot_mapped;
  dadec_pkg::dadec_sel_t o_data_sel, o_code_sel;
  logic [11:0] o_data_boot_addr, o_code_boot_addr;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;

  assign i_hready = o_hreadyout;
  dadec_top DUT (.i_mclk, .i_rst_n, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
    .i_hsize, .i_hwdata, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp,
    .i_serial_mode_pin, .i_data_req, .i_data_we, .i_data_addr,
    .i_data_wdata, .o_data_sel, .o_data_boot_addr, .o_data_rdata,
    .o_data_rvalid, .i_periph_rdata, .i_boot_rdata, .i_flash_rdata,
    .i_code_req, .i_code_addr, .o_code_sel, .o_code_boot_addr,
    .o_boot_mapped);
  dadec_targets u_targets (.i_mclk, .i_rst_n, .i_sel(o_data_sel),
    .i_addr(i_data_addr), .i_boot_addr(o_data_boot_addr),
    .o_periph_rdata(i_periph_rdata), .o_boot_rdata(i_boot_rdata),
    .o_flash_rdata(i_flash_rdata));

  initial begin
    i_mclk = 0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  task automatic stop_test;
    if (n_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_rdy;
    int n;
    n = 0;
    @(negedge i_mclk);
    while (o_hreadyout !== 1'b1 && n < 20) begin
      n++;
      @(negedge i_mclk);
    end
    if (n >= 20) chk(32'h0BAD, 32'h0000);
  endtask : wait_rdy

  // address phase held until hready, then data phase held until hready
  task automatic ahb(input logic wr, input logic [31:0] a,
    input logic [31:0] wd, output logic [31:0] r);
    @(posedge i_mclk);
    i_hsel <= 1'b1;
    i_htrans <= 2'b10;
    i_haddr <= a;
    i_hwrite <= wr;
    wait_rdy();
    @(posedge i_mclk);
    i_htrans <= 2'b00;
    i_hwdata <= wd;
    wait_rdy();
    r = o_hrdata;
    chk(o_hresp, 1'b0);
    @(posedge i_mclk);
  endtask : ahb

  task automatic cpu(input logic we, input logic [15:0] a,
    input logic [7:0] wd, input logic [6:0] es, input logic [7:0] er);
    @(posedge i_mclk);
    i_data_req <= 1'b1;
    i_data_we <= we;
    i_data_addr <= a;
    i_data_wdata <= wd;
    #1 chk(o_data_sel, es);
    @(posedge i_mclk);
    i_data_req <= 1'b0;
    i_data_we <= 1'b0;
    if (!we) begin
      @(posedge i_mclk);
      #1 chk(o_data_rvalid, 1'b1);
      chk(o_data_rdata, er);
    end
  endtask : cpu

  task automatic code(input logic [15:0] a, input logic [1:0] ebf,
    input logic [11:0] ba);
    @(posedge i_mclk);
    i_code_req <= 1'b1;
    i_code_addr <= a;
    #1 chk({o_code_sel.boot, o_code_sel.flash}, ebf);
    if (ebf[1]) chk(o_code_boot_addr, ba);
    @(posedge i_mclk);
    i_code_req <= 1'b0;
  endtask : code

  task automatic t_reset;
    ahb(0, 32'h3F48, 0, rd); chk(rd, 8'h40);
    ahb(0, 32'h3F40, 0, rd); chk(rd, 8'h40);
    ahb(0, 32'h3F4C, 0, rd); chk(rd, 0);
    chk(o_boot_mapped, 0);
    code(16'h1000, 2'b00, 0);
  endtask : t_reset

  // reserved peripheral places are never touched here
  task automatic t_decode;
    logic [15:0] ad[12] = '{16'h0000, 16'h003F, 16'h0F00, 16'h0FFF,
      16'h0E40, 16'h0EFF, 16'h1000, 16'h17FF, 16'h8000, 16'hFFFF,
      16'h0900, 16'h1800};
    logic [6:0] sl[12] = '{7'h40, 7'h40, 7'h20, 7'h20, 7'h10, 7'h10,
      7'h01, 7'h01, 7'h02, 7'h02, 7'h00, 7'h00};
    logic [7:0] dt[12] = '{8'h3C, 8'h03, 8'h3C, 8'hC3, 8'h7C, 8'hC3,
      8'hFF, 8'hFF, 8'h96, 8'h69, 8'h00, 8'h00};
    for (int i = 0; i < 12; i++) begin
      cpu(0, ad[i], 0, sl[i], dt[i]);
    end
  endtask : t_decode

  task automatic t_ram;
    cpu(1, 16'h0040, 8'h5A, 7'h08, 0);
    cpu(1, 16'h083F, 8'hA5, 7'h08, 0);
    cpu(0, 16'h0040, 0, 7'h08, 8'h5A);
    cpu(0, 16'h083F, 0, 7'h08, 8'hA5);
  endtask : t_ram

  task automatic commit(input logic [7:0] h, input logic [7:0] k);
    ahb(1, 32'h3F40, h, rd);
    ahb(1, 32'h3F44, k, rd);
    @(posedge i_mclk);
  endtask : commit

  task automatic t_boot;
    commit(8'h50, 8'h55);
    #1 chk(o_boot_mapped, 0);
    ahb(0, 32'h3F48, 0, rd); chk(rd, 8'h40);
    ahb(0, 32'h3F40, 0, rd); chk(rd, 8'h50);
    cpu(0, 16'h1000, 0, 7'h01, 8'hFF);
    ahb(1, 32'h3F44, 8'hD5, rd);
    @(posedge i_mclk);
    #1 chk(o_boot_mapped, 1);
    ahb(0, 32'h3F48, 0, rd); chk(rd, 8'h50);
    cpu(0, 16'h1000, 0, 7'h04, 8'hC3);
    cpu(0, 16'h17FF, 0, 7'h04, 8'h4C);
    cpu(0, 16'h1800, 0, 7'h00, 8'h00);
    code(16'h17FF, 2'b10, 12'h7FF);
    code(16'h8000, 2'b01, 0);
    code(16'h1800, 2'b00, 0);
  endtask : t_boot

  // serial strap goes through a two-flop synchroniser
  task automatic t_serial;
    @(posedge i_mclk);
    i_serial_mode_pin <= 1'b1;
    repeat (4) @(posedge i_mclk);
    code(16'h1800, 2'b10, 12'h800);
    cpu(0, 16'h1800, 0, 7'h04, 8'h43);
    @(posedge i_mclk);
    i_serial_mode_pin <= 1'b0;
    repeat (4) @(posedge i_mclk);
    commit(8'h40, 8'hD5);
    #1 chk(o_boot_mapped, 0);
    cpu(0, 16'h17FF, 0, 7'h01, 8'hFF);
  endtask : t_serial

  initial begin
    i_rst_n = 0;
    i_hsel = 0;
    i_haddr = 0;
    i_htrans = 0;
    i_hwrite = 0;
    i_hsize = 3'h2;
    i_hwdata = 0;
    i_serial_mode_pin = 0;
    i_data_req = 0;
    i_data_we = 0;
    i_data_addr = 0;
    i_data_wdata = 0;
    i_code_req = 0;
    i_code_addr = 0;
    repeat (8) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_mclk);
    t_reset();
    t_decode();
    t_ram();
    t_boot();
    t_serial();
    stop_test();
  end
endmodule : data_area_map_decoder_tb_top
